// [hdl/ddc_pkg.sv]
// Constants, types and helpers shared by the downconverter control bank.
// Assumes one sample clock, a synchronous active-high reset and an APB master.
// How it works
// RULE_01 - Top offset byte holds bits 47..40 of the two's complement phase offset.
// RULE_02 - Five lower offset bytes sit in consecutive registers, least significant first.
// RULE_03 - Q test enable swaps first downconverter Q samples for generator B output.
// RULE_04 - I test enable swaps first downconverter I samples for generator A output.
// RULE_05 - Generator pattern comes from a separate four-bit select field.
// RULE_06 - Mixer select zero gives a real mixer; software routes one channel.
// RULE_07 - Mixer select one gives a complex mixer; software routes quadrature channels.
// RULE_08 - Gain select one multiplies the second downconverter output by two.
// RULE_09 - IF mode field: variable, zero hertz, sample rate, test.
// RULE_10 - Complex-to-real clear: both I and Q outputs carry valid data.
// RULE_11 - Complex-to-real set: extra quarter-sample-rate mixing, only real I output.
// RULE_12 - Reserved bits read zero and writes to them change nothing.
package ddc_pkg;

  // ==========================================================
  // Widths
  localparam int SAMPLE_W = 16;
  localparam int APB_ADDR_W = 13;
  localparam int PHASE_OFS_BYTES = 6;

  // ==========================================================
  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_PHASE_OFS0 = 12'h31D;
  localparam logic [11:0] IDX_PHASE_OFS5 = 12'h322;
  localparam logic [11:0] IDX_TEST_EN = 12'h327;
  localparam logic [11:0] IDX_SECOND_CTRL = 12'h330;
  localparam logic [11:0] IDX_PATTERN_SEL = 12'h550;

  // ==========================================================
  // Field positions and writable masks
  localparam int TEST_EN_I_BIT = 0;
  localparam int TEST_EN_Q_BIT = 2;
  localparam int C2R_BIT = 3;
  localparam int IF_MODE_LSB = 4;
  localparam int GAIN_BIT = 6;
  localparam int MIX_BIT = 7;
  localparam logic [7:0] TEST_EN_MASK = 8'h05;
  localparam logic [7:0] SECOND_CTRL_MASK = 8'hF8;
  localparam logic [7:0] PATTERN_MASK = 8'h0F;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] PHASE_OFS_RST = 8'h00;
  localparam logic [7:0] TEST_EN_RST = 8'h00;
  localparam logic [7:0] SECOND_CTRL_RST = 8'h00;
  localparam logic [7:0] PATTERN_RST = 8'h00;
  localparam logic [1:0] C2R_PHASE_RST = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    DDC_IF_VARIABLE = 2'b00,
    DDC_IF_ZERO_HZ = 2'b01,
    DDC_IF_FS = 2'b10,
    DDC_IF_TEST = 2'b11
  } ddc_if_mode_t;

  typedef enum logic [3:0] {
    DDC_PAT_OFF = 4'b0000,
    DDC_PAT_MIDSCALE = 4'b0001,
    DDC_PAT_POS_FS = 4'b0010,
    DDC_PAT_NEG_FS = 4'b0011,
    DDC_PAT_CHECKER = 4'b0100,
    DDC_PAT_RAMP = 4'b0101
  } ddc_pat_t;

  typedef struct packed {
    logic signed [SAMPLE_W-1:0] i;
    logic signed [SAMPLE_W-1:0] q;
  } ddc_iq_t;

  typedef struct packed {
    logic complex_mix;
    logic gain_x2;
    ddc_if_mode_t if_mode;
    logic c2r;
  } ddc_ctrl_t;

  // ==========================================================
  // Saturating helpers, shared by the output stage
  function automatic logic signed [SAMPLE_W-1:0] ddc_sat_dbl(input logic signed [SAMPLE_W-1:0] x);
    if (x[SAMPLE_W-1] != x[SAMPLE_W-2]) begin
      return x[SAMPLE_W-1] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    return {x[SAMPLE_W-2:0], 1'b0};
  endfunction : ddc_sat_dbl

  function automatic logic signed [SAMPLE_W-1:0] ddc_sat_neg(input logic signed [SAMPLE_W-1:0] x);
    if (x == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
      return {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    return -x;
  endfunction : ddc_sat_neg

endpackage : ddc_pkg

// [hdl/ddc_test_gen.sv]
// Test pattern generator feeding one sample lane.
// Assumes the select field is steady-state register content on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ddc_test_gen import ddc_pkg::*; #(
  parameter int W = SAMPLE_W,
  parameter bit ALT_PHASE = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [3:0] pattern_i,
  output logic [W-1:0] data_o
);

  // Checkerboard needs an even width to tile the two-bit cell
  if (W < 4 || W % 2 != 0) begin : g_width_check
    $error("ddc_test_gen: width must be even and at least four");
  end

  logic [W-1:0] ramp_r;
  logic flip_r;

  // ==========================================================
  // Free-running pattern state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramp_r <= '0;
      flip_r <= 1'b0;
    end else if (ce_i) begin
      ramp_r <= ramp_r + 1'b1;
      flip_r <= ~flip_r;
    end
  end

  // ==========================================================
  // RULE_05 pattern from select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= '0;
    end else if (ce_i) begin
      case (ddc_pat_t'(pattern_i))
        DDC_PAT_MIDSCALE: data_o <= '0;
        DDC_PAT_POS_FS: data_o <= {1'b0, {(W-1){1'b1}}};
        DDC_PAT_NEG_FS: data_o <= {1'b1, {(W-1){1'b0}}};
        DDC_PAT_CHECKER: data_o <= (flip_r ^ ALT_PHASE) ? {(W/2){2'b10}} : {(W/2){2'b01}};
        DDC_PAT_RAMP: data_o <= ramp_r;
        default: data_o <= '0;
      endcase
    end
  end

endmodule : ddc_test_gen
`default_nettype wire

// [hdl/ddc_second_stage.sv]
// Output stage of the second downconverter: mixer routing, gain, complex to real.
// Assumes samples and control arrive on the same clock, already synchronous.
`timescale 1ns/1ps
`default_nettype none
module ddc_second_stage import ddc_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire ddc_ctrl_t ctrl_i,
  input wire ddc_iq_t data_i,
  input wire logic valid_i,
  output ddc_iq_t data_o,
  output logic i_valid_o,
  output logic q_valid_o
);

  ddc_iq_t mix;
  ddc_iq_t gained;
  logic signed [SAMPLE_W-1:0] real_nxt;
  logic [1:0] phase_r;

  always_comb begin
    // RULE_06 real mixer, one lane
    mix.i = data_i.i;
    mix.q = ctrl_i.complex_mix ? data_i.q : data_i.i;
    // RULE_08 optional times two
    gained.i = ctrl_i.gain_x2 ? ddc_sat_dbl(mix.i) : mix.i;
    gained.q = ctrl_i.gain_x2 ? ddc_sat_dbl(mix.q) : mix.q;
    // RULE_11 quarter-rate rotation
    case (phase_r)
      2'd0: real_nxt = gained.i;
      2'd1: real_nxt = ddc_sat_neg(gained.q);
      2'd2: real_nxt = ddc_sat_neg(gained.i);
      default: real_nxt = gained.q;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= C2R_PHASE_RST;
    end else if (ce_i && valid_i) begin
      phase_r <= ctrl_i.c2r ? phase_r + 2'd1 : C2R_PHASE_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= '0;
      i_valid_o <= 1'b0;
      q_valid_o <= 1'b0;
    end else if (ce_i) begin
      i_valid_o <= valid_i;
      if (ctrl_i.c2r) begin
        // RULE_11 real I only
        data_o.i <= real_nxt;
        data_o.q <= '0;
        q_valid_o <= 1'b0;
      end else begin
        // RULE_10 both lanes valid
        data_o <= gained;
        q_valid_o <= valid_i;
      end
    end
  end

endmodule : ddc_second_stage
`default_nettype wire

// [hdl/ddc_control_regs.sv]
// Downconverter control bank: APB registers, test substitution, second stage.
// Assumes an APB master on clk_i; sample lanes come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module ddc_control_regs import ddc_pkg::*; #(
  parameter int ADDR_W = APB_ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire ddc_iq_t first_in_i,
  input wire logic first_valid_i,
  output ddc_iq_t first_out_o,
  output logic first_valid_o,
  input wire ddc_iq_t second_in_i,
  input wire logic second_valid_i,
  output ddc_iq_t second_out_o,
  output logic second_i_valid_o,
  output logic second_q_valid_o,
  output logic [47:0] phase_offset_o,
  output logic [1:0] if_mode_o,
  output logic mixer_complex_o
);

  // Highest index needs thirteen byte-address bits
  if (ADDR_W < 13) begin : g_addr_check
    $error("ddc_control_regs: address too narrow for the map");
  end

  // ==========================================================
  // Register state
  logic [7:0] phase_ofs_r [PHASE_OFS_BYTES];
  logic [7:0] test_en_r;
  logic [7:0] second_ctrl_r;
  logic [7:0] pattern_r;
  ddc_ctrl_t ctrl;

  // ==========================================================
  // Address decode
  logic [11:0] idx;
  logic aligned;
  logic hit_phase;
  logic hit_test;
  logic hit_ctrl;
  logic hit_pat;
  logic mapped;
  logic wr_fire;
  logic [2:0] phase_sel;
  logic [7:0] rd_byte;

  assign idx = 12'(paddr_i[ADDR_W-1:2]);
  assign aligned = (paddr_i[1:0] == 2'b00);
  // RULE_02 consecutive offset bytes
  assign hit_phase = aligned && idx >= IDX_PHASE_OFS0 && idx <= IDX_PHASE_OFS5;
  assign hit_test = aligned && idx == IDX_TEST_EN;
  assign hit_ctrl = aligned && idx == IDX_SECOND_CTRL;
  assign hit_pat = aligned && idx == IDX_PATTERN_SEL;
  assign mapped = hit_phase | hit_test | hit_ctrl | hit_pat;
  assign phase_sel = 3'(idx - IDX_PHASE_OFS0);

  // Write lands only at the access edge where pready is seen high
  assign wr_fire = ce_i && psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && mapped;

  // ==========================================================
  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    if (hit_phase) begin
      rd_byte = phase_ofs_r[phase_sel];
    end else if (hit_test) begin
      // RULE_12 reserved reads zero
      rd_byte = test_en_r & TEST_EN_MASK;
    end else if (hit_ctrl) begin
      rd_byte = second_ctrl_r & SECOND_CTRL_MASK;
    end else if (hit_pat) begin
      rd_byte = pattern_r & PATTERN_MASK;
    end
  end

  // ==========================================================
  // APB handshake: no wait state, answer registered at setup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      if (psel_i && !penable_i) begin
        pready_o <= 1'b1;
        prdata_o <= (!pwrite_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        pslverr_o <= !mapped;
      end else begin
        pready_o <= 1'b0;
        prdata_o <= 32'h0000_0000;
        pslverr_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Phase offset bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < PHASE_OFS_BYTES; k++) begin
        phase_ofs_r[k] <= PHASE_OFS_RST;
      end
    end else if (wr_fire && hit_phase) begin
      phase_ofs_r[phase_sel] <= pwdata_i[7:0];
    end
  end

  // Word stays two's complement; the oscillator sign-extends from bit 47
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_offset_o <= 48'h0000_0000_0000;
    end else if (ce_i) begin
      // RULE_01 top byte is 47..40
      phase_offset_o <= {phase_ofs_r[5], phase_ofs_r[4], phase_ofs_r[3],
                         phase_ofs_r[2], phase_ofs_r[1], phase_ofs_r[0]};
    end
  end

  // ==========================================================
  // Test enable, control and pattern select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_en_r <= TEST_EN_RST;
    end else if (wr_fire && hit_test) begin
      // RULE_12 reserved writes dropped
      test_en_r <= pwdata_i[7:0] & TEST_EN_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      second_ctrl_r <= SECOND_CTRL_RST;
    end else if (wr_fire && hit_ctrl) begin
      second_ctrl_r <= pwdata_i[7:0] & SECOND_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pattern_r <= PATTERN_RST;
    end else if (wr_fire && hit_pat) begin
      pattern_r <= pwdata_i[7:0] & PATTERN_MASK;
    end
  end

  // ==========================================================
  // Control fields toward the second downconverter
  always_comb begin
    // RULE_06 RULE_07 mixer kind
    ctrl.complex_mix = second_ctrl_r[MIX_BIT];
    // RULE_08 gain select
    ctrl.gain_x2 = second_ctrl_r[GAIN_BIT];
    // RULE_09 IF mode decode
    ctrl.if_mode = ddc_if_mode_t'(second_ctrl_r[IF_MODE_LSB +: 2]);
    // RULE_10 RULE_11 output form
    ctrl.c2r = second_ctrl_r[C2R_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      if_mode_o <= DDC_IF_VARIABLE;
      mixer_complex_o <= 1'b0;
    end else if (ce_i) begin
      if_mode_o <= ctrl.if_mode;
      mixer_complex_o <= ctrl.complex_mix;
    end
  end

  // ==========================================================
  // First downconverter test substitution
  logic [SAMPLE_W-1:0] gen_a;
  logic [SAMPLE_W-1:0] gen_b;

  // RULE_05 one select, two generators
  ddc_test_gen #(
    .W(SAMPLE_W),
    .ALT_PHASE(1'b0)
  ) u_gen_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pattern_i(pattern_r[3:0]),
    .data_o(gen_a)
  );

  ddc_test_gen #(
    .W(SAMPLE_W),
    .ALT_PHASE(1'b1)
  ) u_gen_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pattern_i(pattern_r[3:0]),
    .data_o(gen_b)
  );

  // Generators run freely, so a pattern is not aligned to sample valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      first_out_o <= '0;
      first_valid_o <= 1'b0;
    end else if (ce_i) begin
      first_valid_o <= first_valid_i;
      // RULE_04 I from generator A
      first_out_o.i <= test_en_r[TEST_EN_I_BIT] ? gen_a : first_in_i.i;
      // RULE_03 Q from generator B
      first_out_o.q <= test_en_r[TEST_EN_Q_BIT] ? gen_b : first_in_i.q;
    end
  end

  // ==========================================================
  // Second downconverter output stage
  ddc_second_stage u_second (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .ctrl_i(ctrl),
    .data_i(second_in_i),
    .valid_i(second_valid_i),
    .data_o(second_out_o),
    .i_valid_o(second_i_valid_o),
    .q_valid_o(second_q_valid_o)
  );

endmodule : ddc_control_regs
`default_nettype wire

// [test/ddc_chk.sv]
// Port checker for the downconverter control bank.
// Assumes ce_i stays high around register writes.
`timescale 1ns/1ps
`default_nettype none
module ddc_chk import ddc_pkg::*; #(
  parameter int ADDR_W = APB_ADDR_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic first_valid_i,
  input wire logic first_valid_o,
  input wire logic second_valid_i,
  input wire ddc_iq_t second_out_o,
  input wire logic second_i_valid_o,
  input wire logic second_q_valid_o,
  input wire logic [47:0] phase_offset_o,
  input wire logic [1:0] if_mode_o,
  input wire logic mixer_complex_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================
  // Write commit; the exported copy moves one cycle later
  sequence wr_s(logic [11:0] idx);
    ce_i && psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0]
      && paddr_i == ADDR_W'({idx, 2'b00});
  endsequence
  ans_timely_a: assert property (psel_i && !penable_i && ce_i |=> pready_o)
    else $error("no answer after setup");
  err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == '0)
    else $error("error answer with data");
  rd_upper_a: assert property (pready_o |-> prdata_o[31:8] == '0)
    else $error("upper read bits set");
  phase_top_a: assert property (wr_s(IDX_PHASE_OFS5) |-> ##2
    phase_offset_o[47:40] == $past(pwdata_i[7:0], 2)) else $error("top byte not exported");
  mixer_sel_a: assert property (wr_s(IDX_SECOND_CTRL) |-> ##2
    mixer_complex_o == $past(pwdata_i[7], 2)) else $error("mixer select wrong");
  if_mode_a: assert property (wr_s(IDX_SECOND_CTRL) |-> ##2
    if_mode_o == $past(pwdata_i[5:4], 2)) else $error("if mode wrong");
  first_val_a: assert property (ce_i |=> first_valid_o == $past(first_valid_i))
    else $error("first valid latency wrong");
  i_val_a: assert property (ce_i |=> second_i_valid_o == $past(second_valid_i))
    else $error("second valid latency wrong");
  q_val_a: assert property (second_q_valid_o |-> second_i_valid_o)
    else $error("q valid without i valid");
  real_only_a: assert property (second_i_valid_o && !second_q_valid_o |->
    second_out_o.q == '0) else $error("q lane not zero in real mode");
endmodule : ddc_chk
`default_nettype wire

// [test/ddc_control_registers_test.sv]
// Self-checking bench for the downconverter control bank.
// Assumes a 10 MHz clock; the checker is bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module ddc_control_registers_test import ddc_pkg::*;;
  localparam logic [12:0] A_PH = 13'({IDX_PHASE_OFS0, 2'b00});
  localparam logic [12:0] A_TE = 13'({IDX_TEST_EN, 2'b00});
  localparam logic [12:0] A_CT = 13'({IDX_SECOND_CTRL, 2'b00});
  localparam logic [12:0] A_PS = 13'({IDX_PATTERN_SEL, 2'b00});
  localparam logic [15:0] ROT [4] = '{16'h1234, 16'hFA99, 16'hEDCC, 16'h0567};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [12:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = '0;
  logic [31:0] prdata;
  logic pready, pslverr, fv, siv, sqv, cplx, er, vin = 1'b0;
  logic [1:0] ifm;
  logic [47:0] phase;
  logic [31:0] rd;
  ddc_iq_t din = '0;
  ddc_iq_t fout, sout;
  int num_errors = 0;
  int n_tests = 0;
  ddc_control_regs i_ddc_control_regs (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .first_in_i(din), .first_valid_i(vin), .first_out_o(fout), .first_valid_o(fv),
    .second_in_i(din), .second_valid_i(vin), .second_out_o(sout),
    .second_i_valid_o(siv), .second_q_valid_o(sqv), .phase_offset_o(phase),
    .if_mode_o(ifm), .mixer_complex_o(cplx)
  );
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ==========================================
  // Access and compare tasks
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [12:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge clk_i);
    pen <= 1'b1;
    @(posedge clk_i);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask : wr
  task automatic rchk(input logic [12:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00, 4'h0);
    chk({rd, er}, {24'h00_0000, e, ee});
  endtask : rchk
  // One valid sample on both lanes, outputs settled on return
  task automatic samp(input ddc_iq_t d);
    @(posedge clk_i);
    din <= d;
    vin <= 1'b1;
    @(posedge clk_i);
    vin <= 1'b0;
    #1;
  endtask : samp
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ==========================================
  // Test sequence
  initial begin
    int k;
    int p;
    logic [15:0] ei, eq, fs, ramp0;
    logic [7:0] c;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (k = 0; k < 6; k++) rchk(A_PH + 13'(4 * k), PHASE_OFS_RST, 1'b0);
    rchk(A_TE, TEST_EN_RST, 1'b0);
    rchk(A_CT, SECOND_CTRL_RST, 1'b0);
    rchk(A_PS, PATTERN_RST, 1'b0);
    for (k = 0; k < 6; k++) begin
      wr(A_PH + 13'(4 * k), 8'(k == 5 ? 8'h9A : 8'h11 * (k + 1)));
    end
    repeat (2) @(posedge clk_i);
    chk(phase, 48'h9A55_4433_2211);
    rchk(A_PH + 13'h0014, 8'h9A, 1'b0);
    wr(A_PH, 8'h00);
    repeat (2) @(posedge clk_i);
    chk(phase, 48'h9A55_4433_2200);
    wr(A_TE, 8'hFF);
    rchk(A_TE, 8'h05, 1'b0);
    apb(1'b1, A_TE, 8'h00, 4'h0);
    rchk(A_TE, 8'h05, 1'b0);
    wr(A_CT, 8'hFF);
    rchk(A_CT, 8'hF8, 1'b0);
    wr(A_PS, 8'hFF);
    rchk(A_PS, 8'h0F, 1'b0);
    rchk(13'h0004, 8'h00, 1'b1);
    rchk(A_TE + 13'h0001, 8'h00, 1'b1);
    wr(A_CT, 8'h80);
    // Midscale, positive and negative full scale, each through every enable
    for (p = 1; p < 4; p++) begin
      wr(A_PS, 8'(p));
      fs = (p == 1) ? 16'h0000 : (p == 2) ? 16'h7FFF : 16'h8000;
      for (k = 0; k < 6; k++) begin
        c = 8'(k);
        wr(A_TE, c);
        samp({16'h1234, 16'h0567});
        ei = c[0] ? fs : 16'h1234;
        eq = c[2] ? fs : 16'h0567;
        chk({fv, fout}, {1'b1, ei, eq});
      end
    end
    // Checkerboard: the Q generator runs in the opposite phase to the I one
    wr(A_PS, 8'h04);
    samp({16'h1234, 16'h0567});
    ei = fout.i;
    eq = fout.q;
    chk({ei == 16'h5555 || ei == 16'hAAAA, ei ^ eq}, {1'b1, 16'hFFFF});
    // Ramp: two samples two cycles apart differ by two
    wr(A_PS, 8'h05);
    samp({16'h1234, 16'h0567});
    ramp0 = fout.i;
    samp({16'h1234, 16'h0567});
    chk(16'(fout.i - ramp0), 16'h0002);
    for (k = 0; k < 4; k++) begin
      c = 8'(8'h50 * k);
      wr(A_CT, c);
      samp({16'h1234, 16'h0567});
      ei = c[6] ? 16'h2468 : 16'h1234;
      eq = c[7] ? (c[6] ? 16'h0ACE : 16'h0567) : ei;
      chk({cplx, ifm}, {c[7], c[5:4]});
      chk({siv, sqv, sout}, {2'b11, ei, eq});
    end
    wr(A_CT, 8'h88);
    for (k = 0; k < 5; k++) begin
      samp({16'h1234, 16'h0567});
      chk({siv, sqv, sout}, {2'b10, ROT[k % 4], 16'h0000});
    end
    // Clock enable low: a valid sample neither lands nor turns the rotation
    @(posedge clk_i);
    ce <= 1'b0;
    samp({16'h1234, 16'h0567});
    chk({siv, sqv, sout}, {2'b00, ROT[1], 16'h0000});
    @(posedge clk_i);
    ce <= 1'b1;
    samp({16'h1234, 16'h0567});
    chk({siv, sqv, sout}, {2'b10, ROT[1], 16'h0000});
    summarize();
  end
  // Cuts a hang well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    summarize();
  end
endmodule : ddc_control_registers_test
bind ddc_control_regs ddc_chk #(.ADDR_W(ADDR_W)) i_ddc_chk (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .first_valid_i(first_valid_i), .first_valid_o(first_valid_o),
  .second_valid_i(second_valid_i), .second_out_o(second_out_o),
  .second_i_valid_o(second_i_valid_o), .second_q_valid_o(second_q_valid_o),
  .phase_offset_o(phase_offset_o), .if_mode_o(if_mode_o), .mixer_complex_o(mixer_complex_o)
);
`default_nettype wire
